/* irq_route_pkg.sv */
// Constants and carrier types for the cascaded interrupt router
// Operation
// [RULE_01] Sixteen request lines 0..15, eight on primary and eight on secondary controller.
// [RULE_02] Secondary controller output drives primary request input 2.
// [RULE_03] Line 9 replaces legacy bus request 2; firmware may make it deliver vector 0Ah.
// [RULE_04] Primary: lower number wins, line 0 highest, line 7 lowest.
// [RULE_05] Lines 8..15 ranked inside primary slot 2, so they outrank 3..7.
// [RULE_06] After power-up every request line is masked and vectors are defined.
// [RULE_07] Primary lines 0..7 give vectors 08h..0Fh; timer on 0, keyboard on 1.
// [RULE_08] Secondary lines 8..15 give vectors 70h..77h; secondary disk on 15.
// [RULE_09] Real-time clock on 8, coprocessor on 13, primary disk on 14.
// [RULE_10] I/O channel check raises the non-maskable interrupt, vector 2.
// [RULE_11] System-management interrupt ignores masks and bypasses the vectored controllers.
// [RULE_12] A switchable source disabled in setup loses its function and frees its line.
// [RULE_13] Add-on cards should not drive lines already taken by on-board sources.
package irq_route_pkg;

   localparam int NUM_LINES = 16;
   localparam int SLICE_LINES = 8;
   localparam int CASCADE_INPUT = 2;
   localparam int LEGACY_BUS_LINE = 2;
   localparam int LEGACY_LINE = 9;
   localparam int LINE_TIMER0 = 0;
   localparam int LINE_KBD = 1;
   localparam int LINE_COM2 = 3;
   localparam int LINE_COM1 = 4;
   localparam int LINE_SOUND = 5;
   localparam int LINE_FDC = 6;
   localparam int LINE_LPT1 = 7;
   localparam int LINE_RTC = 8;
   localparam int LINE_FIELDBUS = 10;
   localparam int LINE_MOUSE = 12;
   localparam int LINE_FPU = 13;
   localparam int LINE_HD1 = 14;
   localparam int LINE_HD2 = 15;

   // Vector numbers presented to the core
   localparam logic [7:0] VEC_PRI_BASE = 8'h08;
   localparam logic [7:0] VEC_SEC_BASE = 8'h70;
   localparam logic [7:0] VEC_NMI = 8'h02;
   localparam logic [7:0] VEC_LEGACY = 8'h0a;
   // Answer to an acknowledge with nothing pending: lowest primary slot
   localparam logic [7:0] VEC_SPURIOUS = 8'h0f;

   // Reset values
   localparam logic [15:0] MASK_RESET = 16'hffff;
   localparam logic [7:0] VECTOR_RESET = 8'h00;

   // Acknowledge sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01
   } ack_state_t;

   // On-board request sources, one bit each
   typedef struct packed {
      logic timer0;
      logic kbd;
      logic com2;
      logic com1;
      logic sound;
      logic fdc;
      logic lpt1;
      logic rtc;
      logic vga;
      logic fieldbus;
      logic mouse;
      logic fpu;
      logic hd1;
      logic hd2;
   } onboard_src_t;

   // Setup enables for sources that can be switched off
   typedef struct packed {
      logic com2;
      logic com1;
      logic fdc;
      logic lpt1;
      logic mouse;
      logic hd2;
   } switch_en_t;

   // Non-vectored sources
   typedef struct packed {
      logic iochk;
      logic smi;
   } special_src_t;

endpackage

/* irq_slice.sv */
// One eight-input prioritised request controller slice
`timescale 1ns/1ps
`default_nettype none
module irq_slice (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_req,
   input wire logic [7:0] i_mask,
   input wire logic i_ack,
   input wire logic i_eoi,
   output logic o_pending,
   output logic [2:0] o_sel,
   output var logic [7:0] o_in_service
);

   logic [7:0] req_seen;
   logic [7:0] next_in_service;
   logic found;
   logic cleared;

   // Requests are level sensitive; sampling once keeps the resolver glitch free
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         req_seen <= 8'h00;
      end else begin
         req_seen <= i_req;
      end
   end

   // Lowest index wins; an in-service line blocks itself and all below it
   always_comb begin
      o_pending = 1'b0;
      o_sel = 3'h0;
      found = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (!found) begin
            if (o_in_service[i]) begin
               found = 1'b1;
            end else if (req_seen[i] && !i_mask[i]) begin
               o_pending = 1'b1;
               o_sel = 3'(i);
               found = 1'b1;
            end
         end
      end
   end // see [RULE_04] see [RULE_05]

   // End of interrupt retires the highest ranked service bit, then acknowledge sets one
   always_comb begin
      next_in_service = o_in_service;
      cleared = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i_eoi && !cleared && o_in_service[i]) begin
            next_in_service[i] = 1'b0;
            cleared = 1'b1;
         end
      end
      if (i_ack && o_pending) begin
         next_in_service[o_sel] = 1'b1;
      end
   end

   // In-service state
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_in_service <= 8'h00;
      end else begin
         o_in_service <= next_in_service;
      end
   end

endmodule
`default_nettype wire

/* irq_router.sv */
// Cascaded interrupt router: source wiring, masks, special interrupts, acknowledge
`timescale 1ns/1ps
`default_nettype none
module irq_router (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire irq_route_pkg::onboard_src_t i_onboard,
   input wire irq_route_pkg::switch_en_t i_switch_en,
   input wire irq_route_pkg::special_src_t i_special,
   input wire logic [15:0] i_bus_irq,
   input wire logic i_legacy9,
   input wire logic i_mask_wr,
   input wire logic [15:0] i_mask_data,
   input wire logic i_inta,
   input wire logic i_eoi,
   output logic o_int,
   output logic o_nmi,
   output logic o_smi,
   output logic o_vec_valid,
   output logic [7:0] o_vector,
   output logic [15:0] o_mask,
   output logic [15:0] o_in_service
);

   irq_route_pkg::ack_state_t state;
   irq_route_pkg::ack_state_t next_state;
   logic [15:0] line;
   logic [15:0] onboard_line;
   logic [7:0] pri_req;
   logic pri_pending;
   logic [2:0] pri_sel;
   logic [7:0] pri_isr;
   logic sec_pending;
   logic [2:0] sec_sel;
   logic [7:0] sec_isr;
   logic pri_ack;
   logic sec_ack;
   logic sec_eoi;
   logic nmi_pend;
   logic iochk_prev;
   logic take_nmi;
   logic [7:0] next_vector;

   // Sound, video and fieldbus have no setup switch, so they always own their lines
   // On-board sources onto their lines; disabled sources let go of the line
   always_comb begin
      onboard_line = 16'h0000;
      onboard_line[irq_route_pkg::LINE_TIMER0] = i_onboard.timer0; // see [RULE_07]
      onboard_line[irq_route_pkg::LINE_KBD] = i_onboard.kbd; // see [RULE_07]
      onboard_line[irq_route_pkg::LINE_COM2] = i_onboard.com2 & i_switch_en.com2; // see [RULE_12]
      onboard_line[irq_route_pkg::LINE_COM1] = i_onboard.com1 & i_switch_en.com1; // see [RULE_12]
      onboard_line[irq_route_pkg::LINE_SOUND] = i_onboard.sound;
      onboard_line[irq_route_pkg::LINE_FDC] = i_onboard.fdc & i_switch_en.fdc; // see [RULE_12]
      onboard_line[irq_route_pkg::LINE_LPT1] = i_onboard.lpt1 & i_switch_en.lpt1; // see [RULE_12]
      onboard_line[irq_route_pkg::LINE_RTC] = i_onboard.rtc; // see [RULE_09]
      onboard_line[irq_route_pkg::LEGACY_LINE] = i_onboard.vga;
      onboard_line[irq_route_pkg::LINE_FIELDBUS] = i_onboard.fieldbus;
      onboard_line[irq_route_pkg::LINE_MOUSE] = i_onboard.mouse & i_switch_en.mouse; // see [RULE_12]
      onboard_line[irq_route_pkg::LINE_FPU] = i_onboard.fpu; // see [RULE_09]
      onboard_line[irq_route_pkg::LINE_HD1] = i_onboard.hd1; // see [RULE_09]
      onboard_line[irq_route_pkg::LINE_HD2] = i_onboard.hd2 & i_switch_en.hd2; // see [RULE_08] see [RULE_12]
   end

   // Bus lines are merged by OR; a card sharing an on-board line just adds to it
   always_comb begin
      line = onboard_line | i_bus_irq; // see [RULE_13]
      // The bus pin of the old line 2 is carried on line 9
      line[irq_route_pkg::LEGACY_LINE] = onboard_line[irq_route_pkg::LEGACY_LINE]
         | i_bus_irq[irq_route_pkg::LEGACY_LINE]
         | i_bus_irq[irq_route_pkg::LEGACY_BUS_LINE]; // see [RULE_03]
      // Line 2 itself is the cascade input and never seen from outside
      line[irq_route_pkg::CASCADE_INPUT] = 1'b0; // see [RULE_02]
   end

   // Primary inputs: lines 0..7 with the secondary output in slot 2
   always_comb begin
      pri_req = line[7:0];
      pri_req[irq_route_pkg::CASCADE_INPUT] = sec_pending; // see [RULE_02]
   end

   // Trade-off: a write acts on the already sampled requests, so o_int follows a cycle later
   // Mask register, all masked out of reset until software opens lines
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_mask <= irq_route_pkg::MASK_RESET; // see [RULE_06]
      end else if (i_mask_wr) begin
         o_mask <= i_mask_data;
      end
   end

   // Lines 0..7 on the primary slice
   irq_slice u_primary (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_req(pri_req),
      .i_mask(o_mask[7:0]),
      .i_ack(pri_ack),
      .i_eoi(i_eoi),
      .o_pending(pri_pending),
      .o_sel(pri_sel),
      .o_in_service(pri_isr)
   ); // see [RULE_01] see [RULE_04]

   // Lines 8..15 on the secondary slice
   irq_slice u_secondary (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_req(line[15:8]),
      .i_mask(o_mask[15:8]),
      .i_ack(sec_ack),
      .i_eoi(sec_eoi),
      .o_pending(sec_pending),
      .o_sel(sec_sel),
      .o_in_service(sec_isr)
   ); // see [RULE_01] see [RULE_05]

   // Limitation: no nesting inside the secondary; slot 2 stays closed until this end of interrupt
   // One end of interrupt closes the cascade on both slices when slot 2 is on top
   assign sec_eoi = i_eoi && pri_isr[2:0] == 3'b100; // see [RULE_02]

   // The previous level resets low like the idle pin, so no false edge follows reset
   // Channel check is caught on its rising edge; a new edge beats a same-cycle clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         iochk_prev <= 1'b0;
         nmi_pend <= 1'b0;
      end else begin
         iochk_prev <= i_special.iochk;
         if (i_special.iochk && !iochk_prev) begin
            nmi_pend <= 1'b1; // see [RULE_10]
         end else if (take_nmi) begin
            nmi_pend <= 1'b0;
         end
      end
   end

   // Hazard: an NMI taken while a vectored request waits leaves o_int high for the next acknowledge
   // The non-maskable request goes first when the core acknowledges
   assign take_nmi = state == irq_route_pkg::ST_IDLE && i_inta && nmi_pend; // see [RULE_10]

   // Acknowledge routing: only a cascade win also reaches the secondary slice
   always_comb begin
      pri_ack = 1'b0;
      sec_ack = 1'b0;
      if (state == irq_route_pkg::ST_IDLE && i_inta && !nmi_pend && pri_pending) begin
         pri_ack = 1'b1;
         sec_ack = pri_sel == 3'(irq_route_pkg::CASCADE_INPUT); // see [RULE_05]
      end
   end

   // The spurious answer covers a request that dropped between o_int and the acknowledge
   // Vector chosen for the winning source
   always_comb begin
      if (nmi_pend) begin
         next_vector = irq_route_pkg::VEC_NMI; // see [RULE_10]
      end else if (!pri_pending) begin
         next_vector = irq_route_pkg::VEC_SPURIOUS;
      end else if (pri_sel != 3'(irq_route_pkg::CASCADE_INPUT)) begin
         next_vector = irq_route_pkg::VEC_PRI_BASE + {5'h00, pri_sel}; // see [RULE_07]
      end else if (i_legacy9 && sec_sel == 3'(irq_route_pkg::LEGACY_LINE - 8)) begin
         next_vector = irq_route_pkg::VEC_LEGACY; // see [RULE_03]
      end else begin
         next_vector = irq_route_pkg::VEC_SEC_BASE + {5'h00, sec_sel}; // see [RULE_08]
      end
   end

   // Limitation: an acknowledge in the hold cycle is dropped, so the core must space them
   // Sequencer: one hold cycle lets the service bits settle before the next acknowledge
   always_comb begin
      case (state)
         irq_route_pkg::ST_IDLE: begin
            next_state = i_inta ? irq_route_pkg::ST_HOLD : irq_route_pkg::ST_IDLE;
         end
         irq_route_pkg::ST_HOLD: begin
            next_state = irq_route_pkg::ST_IDLE;
         end
         default: begin
            next_state = irq_route_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= irq_route_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Vector answer: valid for exactly one cycle after a taken acknowledge
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_vector <= irq_route_pkg::VECTOR_RESET; // see [RULE_06]
         o_vec_valid <= 1'b0;
      end else begin
         o_vec_valid <= state == irq_route_pkg::ST_IDLE && i_inta;
         if (state == irq_route_pkg::ST_IDLE && i_inta) begin
            o_vector <= next_vector;
         end
      end
   end

   // Registered outputs cost a cycle of latency but keep the pins glitch free
   // Request outputs to the core; management interrupt never sees a mask
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_int <= 1'b0;
         o_nmi <= 1'b0;
         o_smi <= 1'b0;
         o_in_service <= 16'h0000;
      end else begin
         o_int <= pri_pending && !pri_ack; // see [RULE_02]
         o_nmi <= nmi_pend && !take_nmi; // see [RULE_10]
         o_smi <= i_special.smi; // see [RULE_11]
         o_in_service <= {sec_isr, pri_isr};
      end
   end

endmodule
`default_nettype wire

/* irq_router_monitor.sv */
// Port checker for the cascaded interrupt router
`timescale 1ns/1ps
`default_nettype none
module irq_router_monitor (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire irq_route_pkg::special_src_t i_special,
   input wire logic i_mask_wr,
   input wire logic [15:0] i_mask_data,
   input wire logic i_inta,
   input wire logic o_int,
   input wire logic o_nmi,
   input wire logic o_smi,
   input wire logic o_vec_valid,
   input wire logic [7:0] o_vector,
   input wire logic [15:0] o_mask
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // An acknowledge held into the hold cycle is refused, so only a fresh one counts
   sequence ack_taken;
      i_inta && !$past(i_inta);
   endsequence
   // One-cycle answer with the request withdrawn
   sequence ack_answer;
      o_vec_valid && !o_int ##1 !o_vec_valid;
   endsequence
   mask_reset_a: assert property ($fell(i_rst) |-> o_mask == 16'hffff && !o_int)
      else $error("mask not set after reset");
   mask_write_a: assert property (i_mask_wr |=> o_mask == $past(i_mask_data))
      else $error("mask write lost");
   ack_pulse_a: assert property (ack_taken |=> ack_answer)
      else $error("acknowledge answer wrong");
   vec_legal_a: assert property (o_vec_valid |-> o_vector inside {8'h02, [8'h08:8'h0f], [8'h70:8'h77]})
      else $error("vector outside defined sets");
   nmi_raise_a: assert property ($rose(i_special.iochk) |-> ##[2:3] o_nmi)
      else $error("channel check did not raise nmi");
   nmi_vector_a: assert property (o_nmi && i_inta && !$past(i_inta) |=> o_vector == 8'h02)
      else $error("nmi vector wrong");
   smi_follow_a: assert property (!$past(i_rst) |-> o_smi == $past(i_special.smi))
      else $error("smi not passed through");
   // Masks need two cycles of pipeline depth to take effect; the check waits four
   all_masked_a: assert property ((o_mask == 16'hffff && !o_nmi) [*4] |-> !o_int)
      else $error("interrupt through full mask");
endmodule
`default_nettype wire

/* core_model.sv */
// Behavioural processor core taking interrupts and vectors
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_en,
   input wire logic [1:0] i_lag,
   input wire logic i_int,
   input wire logic i_nmi,
   input wire logic i_vec_valid,
   input wire logic [7:0] i_vector,
   output logic o_inta,
   output logic o_got,
   output logic [7:0] o_vec
);
   logic [1:0] cnt;
   logic busy;
   initial o_inta = 1'h0;
   // One acknowledge at a time after a chosen delay; got is sticky until disabled
   always @(posedge i_ref_clk) begin
      o_inta <= 1'h0;
      if (i_rst || !i_en) begin
         cnt <= 2'h0;
         busy <= 1'h0;
         o_got <= 1'h0;
      end else if (busy) begin
         if (i_vec_valid) begin
            busy <= 1'h0;
            o_got <= 1'h1;
            o_vec <= i_vector;
         end
      end else if ((i_int || i_nmi) && !o_got) begin
         if (cnt == i_lag) begin
            o_inta <= 1'h1;
            busy <= 1'h1;
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* test_irq_router.sv */
// Self-checking bench for the cascaded interrupt router
`timescale 1ns/1ps
`default_nettype none
module test_irq_router;
   logic clk, rst, l9, mwr, inta, eoi, cen, got, intr, nmi, smi, vv;
   logic [1:0] lag;
   logic [7:0] vec, cvec;
   logic [15:0] bus, mdat, msk, svc;
   logic [31:0] seed, r, s, t;
   irq_route_pkg::onboard_src_t ob;
   irq_route_pkg::switch_en_t en;
   irq_route_pkg::special_src_t sp;
   int n_fail, check_count;
   irq_router irq_router_i (.i_ref_clk(clk), .i_rst(rst), .i_onboard(ob), .i_switch_en(en), .i_special(sp),
      .i_bus_irq(bus), .i_legacy9(l9), .i_mask_wr(mwr), .i_mask_data(mdat), .i_inta(inta), .i_eoi(eoi),
      .o_int(intr), .o_nmi(nmi), .o_smi(smi), .o_vec_valid(vv), .o_vector(vec), .o_mask(msk), .o_in_service(svc));
   core_model core_model_i (.i_ref_clk(clk), .i_rst(rst), .i_en(cen), .i_lag(lag), .i_int(intr), .i_nmi(nmi),
      .i_vec_valid(vv), .i_vector(vec), .o_inta(inta), .o_got(got), .o_vec(cvec));
   // 125 MHz clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // Steps the generator a full word so draws do not overlap
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      repeat (32) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
      return v;
   endfunction
   // Source wiring onto lines; disabled sources drop off their line
   function automatic logic [15:0] lines_of(input irq_route_pkg::onboard_src_t o, input irq_route_pkg::switch_en_t e,
      input logic [15:0] b);
      return {o.hd2 & e.hd2, o.hd1, o.fpu, o.mouse & e.mouse, b[11], o.fieldbus, o.vga | b[2], o.rtc,
         o.lpt1 & e.lpt1, o.fdc & e.fdc, o.sound, o.com1 & e.com1, o.com2 & e.com2, 1'h0, o.kbd, o.timer0};
   endfunction
   // Winning line, 16 for none; secondary ranks inside slot 2
   function automatic int win(input logic [15:0] l, input logic [15:0] m);
      logic [15:0] a;
      a = l & ~m;
      for (int k = 0; k < 8; k++) begin
         if (k == 2 && !m[2]) begin
            for (int n = 8; n < 16; n++) begin
               if (a[n]) return n;
            end
         end else if (a[k]) begin
            return k;
         end
      end
      return 16;
   endfunction
   function automatic logic [7:0] vec_of(input int w, input logic x);
      if (w < 8) return 8'h08 + 8'(w);
      if (w == 9 && x) return 8'h0a;
      return 8'h70 + 8'(w - 8);
   endfunction
   task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
      check_count++;
      if (got_v !== exp_v) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got_v, exp_v);
      end
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_got;
      for (int k = 0; k < 40 && got !== 1'h1; k++) @(negedge clk);
      if (got !== 1'h1) begin
         n_fail++;
         give_verdict();
      end
   endtask
   // Apply sources and mask, then let the core take and close the winner
   task automatic trial(input irq_route_pkg::onboard_src_t o, input irq_route_pkg::switch_en_t e,
      input logic [15:0] b, input logic [15:0] m, input logic x);
      int w;
      w = win(lines_of(o, e, b), m);
      @(posedge clk);
      ob <= o;
      en <= e;
      bus <= b;
      l9 <= x;
      mdat <= m;
      mwr <= 1'h1;
      @(posedge clk);
      mwr <= 1'h0;
      repeat (5) @(negedge clk);
      check(intr, w < 16);
      if (w < 16) begin
         cen <= 1'h1;
         wait_got();
         check(cvec, vec_of(w, x));
         @(negedge clk);
         check(svc, w < 8 ? 16'h1 << w : 16'h4 | 16'h1 << w);
         @(posedge clk);
         cen <= 1'h0;
         eoi <= 1'h1;
         @(posedge clk);
         eoi <= 1'h0;
         repeat (3) @(negedge clk);
         check(svc, 16'h0);
      end
   endtask
   // Bus requests only on free lines 2 and 11
   initial begin
      rst = 1'h1;
      {ob, en, sp, bus, l9, mwr, mdat, eoi, cen, lag} = '0;
      n_fail = 0;
      check_count = 0;
      seed = 32'h1942;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      check(msk, 16'hffff);
      check(svc, 16'h0);
      trial(14'h0840, 6'h3f, 16'h0, 16'h0, 1'h0);
      trial(14'h0840, 6'h3f, 16'h0, 16'h0004, 1'h0);
      trial(14'h0000, 6'h3f, 16'h0004, 16'h0, 1'h1);
      trial(14'h0401, 6'h2e, 16'h0, 16'h0, 1'h0);
      trial(14'h2006, 6'h3f, 16'h0, 16'h0001, 1'h0);
      trial(14'h3fff, 6'h3f, 16'h0800, 16'hffff, 1'h0);
      // Channel check edge while every line is masked
      @(posedge clk);
      sp <= 2'h2;
      repeat (4) @(negedge clk);
      check(nmi, 1'h1);
      cen <= 1'h1;
      wait_got();
      check(cvec, 8'h02);
      @(posedge clk);
      cen <= 1'h0;
      sp <= 2'h1;
      repeat (3) @(negedge clk);
      check(nmi, 1'h0);
      check({smi, intr}, 2'h2);
      // Request withdrawn as the core acknowledges: spurious answer, nothing goes in service
      @(posedge clk);
      mdat <= 16'hfffe;
      mwr <= 1'h1;
      @(posedge clk);
      mwr <= 1'h0;
      repeat (3) @(posedge clk);
      ob <= 14'h0000;
      cen <= 1'h1;
      wait_got();
      check(cvec, 8'h0f);
      repeat (2) @(negedge clk);
      check(svc, 16'h0);
      @(posedge clk);
      cen <= 1'h0;
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         r = seed;
         seed = lfsr(seed);
         s = seed;
         seed = lfsr(seed);
         t = seed;
         lag <= r[25:24];
         trial(r[13:0] & s[13:0] & t[13:0], r[21:16] | s[21:16], t[15:0] & 16'h0804, s[31:16] & t[31:16], r[31]);
      end
      give_verdict();
   end
endmodule
bind irq_router irq_router_monitor irq_router_monitor_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_special(i_special),
   .i_mask_wr(i_mask_wr), .i_mask_data(i_mask_data), .i_inta(i_inta), .o_int(o_int), .o_nmi(o_nmi), .o_smi(o_smi),
   .o_vec_valid(o_vec_valid), .o_vector(o_vector), .o_mask(o_mask));
`default_nettype wire
